// ### verilog/gpio_wake_pkg.sv
/*
  Shared constants for the four-port GPIO block with pin wake-up:
  register offsets, reset values, field positions and widths.
  Assumes an 8-bit special function register port with a 4-bit address.
*/
package gpio_wake_pkg;

  localparam int PORT_W  = 8;
  localparam int ADDR_W  = 4;
  localparam int WAKE_N  = 4;

  // Register offsets
  localparam logic [3:0] OFS_DIR0   = 4'h0;
  localparam logic [3:0] OFS_DIR1   = 4'h1;
  localparam logic [3:0] OFS_DIR2   = 4'h2;
  localparam logic [3:0] OFS_DIR3   = 4'h3;
  localparam logic [3:0] OFS_DATA0  = 4'h4;
  localparam logic [3:0] OFS_DATA1  = 4'h5;
  localparam logic [3:0] OFS_DATA2  = 4'h6;
  localparam logic [3:0] OFS_DATA3  = 4'h7;
  localparam logic [3:0] OFS_PU0    = 4'h8;
  localparam logic [3:0] OFS_PU1    = 4'h9;
  localparam logic [3:0] OFS_WKEN   = 4'hA;
  localparam logic [3:0] OFS_WKEDGE = 4'hB;

  // Reset values
  localparam logic [7:0] RST_DIR    = 8'hFF;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_PU0    = 8'h00;
  localparam logic [7:0] RST_PU1    = 8'h08;
  localparam logic [3:0] RST_WK_DIS = 4'hF;
  localparam logic [3:0] RST_WK_PND = 4'h0;
  localparam logic [3:0] RST_WK_EDG = 4'h0;

  // Field positions
  localparam int WK_DIS_LSB  = 0;
  localparam int WK_PND_LSB  = 4;
  localparam int P0_PU_BIT   = 7;
  localparam int P0_RSV_HI   = 3;
  localparam int P0_RSV_LO   = 2;

  // Monitored pins: slot 0 P0.4, slot 1 P0.5, slot 2 P3.4, slot 3 P0.7
  localparam int WK0_PIN = 4;
  localparam int WK1_PIN = 5;
  localparam int WK2_PIN = 4;
  localparam int WK3_PIN = 7;

  // Port 0 data bits that hold storage (bits 3:2 reserved)
  localparam logic [7:0] P0_DATA_MASK = 8'hF3;

endpackage

// ### verilog/wake_edge_detect.sv
/*
  One wake-up pin watcher: two-stage synchroniser, then edge detect
  on the selected polarity, giving a one-cycle hit pulse.
  Assumes the pin may be asynchronous to the clock.
*/
`timescale 1ns/1ps
module wake_edge_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic fall_sel,
  output logic      hit
);

  logic       meta_r;
  logic       sync_r;
  logic       prev_r;
  logic [2:0] fill_r;
  logic       hit_nxt;

  // No edge until the chain holds real samples, else a pulled-up pin fakes a rise after reset
  assign hit_nxt = fill_r[2] & (fall_sel ? (prev_r & ~sync_r) : (~prev_r & sync_r));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
      hit    <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
      hit    <= hit_nxt;
    end
  end

endmodule

// ### verilog/gpio_wake.sv
/*
  Four 8-bit GPIO ports with direction, output data, pin readback,
  pull-up control for ports 0 and 1, and a four-pin wake-up unit.
  Assumes a single-master register port with one-cycle strobes and
  a chip reset controller that acts on the wake reset request.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
// Overview of operation
// - After reset the wake enable register reads 0Fh, all four wake pins disarmed.
// - Writing zero to enable bit 0..3 arms wake on P0.4, P0.5, P3.4 (USB lines) or P0.7; one disarms.
// - An edge select bit of one picks the falling edge, zero picks the rising edge.
// - A selected edge sets the pending flag in wake enable bits 7..4, held until software clears it.
// - Reset clears all pending flags.
// - An armed wake event during sleep requests a full chip reset.
// - A direction bit of zero makes the pin an output, one an input; all reset to one.
// - In port 0 direction, bit 2 steers pin 3 and bit 3 steers pin 2.
// - Data writes drive the pin level, data reads return the pin level.
// - Port 0 data bits 3 and 2 are reserved with no GPIO function.
// - Port 0 pull-up bit 7 enables pin 7 pull-up while an input; other bits reserved; reset zero.
// - Port 1 pull-up bit n enables pin n pull-up while that pin is an input.
// - Port 1 pull-up register resets to 08h.
`timescale 1ns/1ps
module gpio_wake
  import gpio_wake_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic [7:0]        P0_IN,
  input  wire logic [7:0]        P1_IN,
  input  wire logic [7:0]        P2_IN,
  input  wire logic [7:0]        P3_IN,
  output logic      [7:0]        P0_OUT,
  output logic      [7:0]        P1_OUT,
  output logic      [7:0]        P2_OUT,
  output logic      [7:0]        P3_OUT,
  output logic      [7:0]        P0_OE_N,
  output logic      [7:0]        P1_OE_N,
  output logic      [7:0]        P2_OE_N,
  output logic      [7:0]        P3_OE_N,
  output logic      [7:0]        P0_PULLUP,
  output logic      [7:0]        P1_PULLUP,
  input  wire logic              SLEEP,
  output logic                   WAKE_RST
);

  // Register state
  logic [7:0] dir0_r;
  logic [7:0] dir1_r;
  logic [7:0] dir2_r;
  logic [7:0] dir3_r;
  logic [7:0] dat0_r;
  logic [7:0] dat1_r;
  logic [7:0] dat2_r;
  logic [7:0] dat3_r;
  logic [7:0] pu0_r;
  logic [7:0] pu1_r;
  logic [3:0] wk_dis_r;
  logic [3:0] wk_pnd_r;
  logic [3:0] wk_edg_r;
  logic [7:0] rdata_r;
  logic       wake_rst_r;
  logic [7:0] p0_pu_out_r;
  logic [7:0] p1_pu_out_r;

  // Next values
  logic [7:0] dir0_nxt;
  logic [7:0] dir1_nxt;
  logic [7:0] dir2_nxt;
  logic [7:0] dir3_nxt;
  logic [7:0] dat0_nxt;
  logic [7:0] dat1_nxt;
  logic [7:0] dat2_nxt;
  logic [7:0] dat3_nxt;
  logic [7:0] pu0_nxt;
  logic [7:0] pu1_nxt;
  logic [3:0] wk_dis_nxt;
  logic [3:0] wk_pnd_nxt;
  logic [3:0] wk_edg_nxt;
  logic [7:0] rdata_nxt;
  logic       wake_rst_nxt;
  logic [7:0] p0_pu_out_nxt;
  logic [7:0] p1_pu_out_nxt;

  // Address decode
  wire wr_dir0  = WR && (ADDR == OFS_DIR0);
  wire wr_dir1  = WR && (ADDR == OFS_DIR1);
  wire wr_dir2  = WR && (ADDR == OFS_DIR2);
  wire wr_dir3  = WR && (ADDR == OFS_DIR3);
  wire wr_dat0  = WR && (ADDR == OFS_DATA0);
  wire wr_dat1  = WR && (ADDR == OFS_DATA1);
  wire wr_dat2  = WR && (ADDR == OFS_DATA2);
  wire wr_dat3  = WR && (ADDR == OFS_DATA3);
  wire wr_pu0   = WR && (ADDR == OFS_PU0);
  wire wr_pu1   = WR && (ADDR == OFS_PU1);
  wire wr_wken  = WR && (ADDR == OFS_WKEN);
  wire wr_wake_edge_select_alt = WR && (ADDR == OFS_WKEDGE);

  // Wake pin sources and detectors
  logic [3:0] wk_pin;
  logic [3:0] wk_hit;

  assign wk_pin[0] = P0_IN[WK0_PIN];
  assign wk_pin[1] = P0_IN[WK1_PIN];
  assign wk_pin[2] = P3_IN[WK2_PIN];
  assign wk_pin[3] = P0_IN[WK3_PIN];

  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi++) begin : g_wake
      wake_edge_detect u_det (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .pin      (wk_pin[gi]),
        .fall_sel (wk_edg_r[gi]),
        .hit      (wk_hit[gi])
      );
    end
  endgenerate

  // Direction and data updates
  assign dir0_nxt = wr_dir0 ? WDATA : dir0_r;
  assign dir1_nxt = wr_dir1 ? WDATA : dir1_r;
  assign dir2_nxt = wr_dir2 ? WDATA : dir2_r;
  assign dir3_nxt = wr_dir3 ? WDATA : dir3_r;

  // Reserved port 0 bits never store, so those pins drive low if enabled
  assign dat0_nxt = wr_dat0 ? (WDATA & P0_DATA_MASK) : dat0_r;
  assign dat1_nxt = wr_dat1 ? WDATA : dat1_r;
  assign dat2_nxt = wr_dat2 ? WDATA : dat2_r;
  assign dat3_nxt = wr_dat3 ? WDATA : dat3_r;

  // Only bit 7 of port 0 pull-up holds state
  assign pu0_nxt = wr_pu0 ? {WDATA[P0_PU_BIT], 7'h00} : pu0_r;
  assign pu1_nxt = wr_pu1 ? WDATA : pu1_r;

  // Wake control: one disarms, zero arms
  assign wk_dis_nxt = wr_wken ? WDATA[WK_DIS_LSB +: WAKE_N] : wk_dis_r;
  assign wk_edg_nxt = wr_wake_edge_select_alt ? WDATA[WAKE_N-1:0] : wk_edg_r;

  // Writing zero clears a pending bit, one leaves it; a new edge wins
  wire [3:0] pnd_keep = wr_wken ? WDATA[WK_PND_LSB +: WAKE_N] : 4'hF;
  assign wk_pnd_nxt = (wk_pnd_r & pnd_keep) | wk_hit;

  // Armed edge while asleep latches a reset request until reset lands
  wire wake_evt = SLEEP && |(wk_hit & ~wk_dis_r);
  assign wake_rst_nxt = wake_rst_r | wake_evt;

  // Pull-ups act only while the pin is an input (port 0 pin 7 unswapped)
  assign p0_pu_out_nxt = pu0_nxt & dir0_nxt & 8'h80;
  assign p1_pu_out_nxt = pu1_nxt & dir1_nxt;

  // Read mux: data registers return the pin level
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      OFS_DIR0:   rd_mux = dir0_r;
      OFS_DIR1:   rd_mux = dir1_r;
      OFS_DIR2:   rd_mux = dir2_r;
      OFS_DIR3:   rd_mux = dir3_r;
      OFS_DATA0:  rd_mux = P0_IN & P0_DATA_MASK;
      OFS_DATA1:  rd_mux = P1_IN;
      OFS_DATA2:  rd_mux = P2_IN;
      OFS_DATA3:  rd_mux = P3_IN;
      OFS_PU0:    rd_mux = pu0_r;
      OFS_PU1:    rd_mux = pu1_r;
      OFS_WKEN:   rd_mux = {wk_pnd_r, wk_dis_r};
      OFS_WKEDGE: rd_mux = {4'h0, wk_edg_r};
      default:    rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  assign rdata_nxt = RD ? rd_mux : 8'h00;

  // Direction: one is input, so every pin starts undriven
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dir0_r <= RST_DIR;
    end else begin
      dir0_r <= dir0_nxt;
    end
  end

  // Port 1 direction also gates the port 1 pull-ups
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dir1_r <= RST_DIR;
    end else begin
      dir1_r <= dir1_nxt;
    end
  end

  // Port 2 direction
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dir2_r <= RST_DIR;
    end else begin
      dir2_r <= dir2_nxt;
    end
  end

  // Port 3 direction; pin 4 must stay an input to watch the USB lines
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dir3_r <= RST_DIR;
    end else begin
      dir3_r <= dir3_nxt;
    end
  end

  // Data reset to zero so a pin turned to output starts low
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dat0_r <= RST_DATA;
    end else begin
      dat0_r <= dat0_nxt;
    end
  end

  // Port 1 output data
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dat1_r <= RST_DATA;
    end else begin
      dat1_r <= dat1_nxt;
    end
  end

  // Port 2 output data
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dat2_r <= RST_DATA;
    end else begin
      dat2_r <= dat2_nxt;
    end
  end

  // Port 3 output data
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dat3_r <= RST_DATA;
    end else begin
      dat3_r <= dat3_nxt;
    end
  end

  // Port 0 pull-up keeps only bit 7
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pu0_r <= RST_PU0;
    end else begin
      pu0_r <= pu0_nxt;
    end
  end

  // Port 1 pull-up, pin 3 on after reset
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pu1_r <= RST_PU1;
    end else begin
      pu1_r <= pu1_nxt;
    end
  end

  // Gated pull-ups registered so the pad sees no decode glitch
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p0_pu_out_r <= RST_PU0;
    end else begin
      p0_pu_out_r <= p0_pu_out_nxt;
    end
  end

  // Port 1 gated pull-ups
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p1_pu_out_r <= RST_PU1;
    end else begin
      p1_pu_out_r <= p1_pu_out_nxt;
    end
  end

  // Wake disable bits; all four disarmed after reset
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wk_dis_r <= RST_WK_DIS;
    end else begin
      wk_dis_r <= wk_dis_nxt;
    end
  end

  // Pending flags; a hit in the clearing cycle survives
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wk_pnd_r <= RST_WK_PND;
    end else begin
      wk_pnd_r <= wk_pnd_nxt;
    end
  end

  // Edge selects, rising after reset
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wk_edg_r <= RST_WK_EDG;
    end else begin
      wk_edg_r <= wk_edg_nxt;
    end
  end

  // Sticky request; only the chip reset it causes clears it
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wake_rst_r <= 1'b0;
    end else begin
      wake_rst_r <= wake_rst_nxt;
    end
  end

  // Read data parks at zero between reads
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops; enable low drives the pin
  assign P0_OUT  = dat0_r;
  assign P1_OUT  = dat1_r;
  assign P2_OUT  = dat2_r;
  assign P3_OUT  = dat3_r;
  assign P0_OE_N = {dir0_r[7:4], dir0_r[P0_RSV_LO], dir0_r[P0_RSV_HI], dir0_r[1:0]};
  assign P1_OE_N = dir1_r;
  assign P2_OE_N = dir2_r;
  assign P3_OE_N = dir3_r;
  assign P0_PULLUP = p0_pu_out_r;
  assign P1_PULLUP = p1_pu_out_r;
  assign WAKE_RST  = wake_rst_r;
  assign RDATA     = rdata_r;

endmodule

// ### sim/gpio_wake_checker.sv
/* Port-level assertions for gpio_wake.
   Assumes it is bound into gpio_wake and sees its ports by name. */
`timescale 1ns/1ps
module gpio_wake_checker
  import gpio_wake_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              RSTN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0]        WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [7:0]        RDATA,
  input wire logic [7:0]        P0_OUT,
  input wire logic [7:0]        P1_OUT,
  input wire logic [7:0]        P0_OE_N,
  input wire logic [7:0]        P1_OE_N,
  input wire logic [7:0]        P0_PULLUP,
  input wire logic [7:0]        P1_PULLUP,
  input wire logic              SLEEP,
  input wire logic              WAKE_RST
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  property p_dir1; WR && ADDR == OFS_DIR1 |=> P1_OE_N == $past(WDATA); endproperty
  a_dir1: assert property (p_dir1) else $error("dir1 write not on enables");
  property p_swap;
    WR && ADDR == OFS_DIR0 |=> P0_OE_N == {$past(WDATA[7:4]), $past(WDATA[2]), $past(WDATA[3]), $past(WDATA[1:0])};
  endproperty
  a_swap: assert property (p_swap) else $error("port0 enable bits wrong");
  property p_out1; WR && ADDR == OFS_DATA1 |=> P1_OUT == $past(WDATA); endproperty
  a_out1: assert property (p_out1) else $error("port1 output wrong");
  property p_rsv; P0_OUT[3:2] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved outputs driven");
  property p_pu0; P0_PULLUP[6:0] == 7'h00 && (P0_PULLUP[7] -> P0_OE_N[7]); endproperty
  a_pu0: assert property (p_pu0) else $error("port0 pull-up wrong");
  property p_pu1; (P1_PULLUP & ~P1_OE_N) == 8'h00; endproperty
  a_pu1: assert property (p_pu1) else $error("pull-up on output pin");
  property p_rst; $rose(RSTN) |-> P1_PULLUP == 8'h08 && P1_OE_N == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_wk_hold; WAKE_RST |=> WAKE_RST; endproperty
  a_wk_hold: assert property (p_wk_hold) else $error("wake reset dropped");
  property p_wk_cause; $rose(WAKE_RST) |-> $past(SLEEP); endproperty
  a_wk_cause: assert property (p_wk_cause) else $error("wake reset while awake");
  property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  c_wake: cover property ($rose(WAKE_RST));
  c_swap: cover property (WR && ADDR == OFS_DIR0);
  c_rd: cover property (RD ##1 RDATA != 8'h00);
endmodule
bind gpio_wake gpio_wake_checker i_chk (.*);

// ### sim/pin_board.sv
/* Board model for all 32 pins.
   Assumes port bits packed port3..port0, pin index = port*8+pin. */
`timescale 1ns/1ps
module pin_board (
  input  wire logic        clk,
  input  wire logic [31:0] drv,
  input  wire logic [31:0] oe_n,
  input  wire logic [31:0] pu,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pin
);
  logic flt_r = 1'b0;
  // Floating pins toggle so a stale level never passes a readback
  always @(posedge clk) flt_r <= ~flt_r;
  // Digital use only, no analogue sharing modelled
  assign pin = (~oe_n & drv) | (oe_n & ((ext_en & ext_val) | (~ext_en & (pu | {32{flt_r}}))));
endmodule

// ### sim/gpio_wake_tb.sv
/* Self-checking bench for gpio_wake: registers, pins, wake-up.
   Assumes pin_board stands for the board and checker is bound. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module gpio_wake_tb;
  import gpio_wake_pkg::*;
  logic REF_CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0, SLEEP = 1'b0, WAKE_RST;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA, P0_IN, P1_IN, P2_IN, P3_IN, P0_OUT, P1_OUT, P2_OUT, P3_OUT;
  logic [7:0] P0_OE_N, P1_OE_N, P2_OE_N, P3_OE_N, P0_PULLUP, P1_PULLUP;
  logic [31:0] ext_en = 32'hFFFF_FFFF, ext_val = 32'h0000_0000;
  int num_errors = 0, cmp_count = 0;
  logic [3:0] ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  logic [7:0] rv [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h08, 8'h0F, 8'h00, 8'h00};
  gpio_wake i_dut (.*);
  pin_board i_board (.clk(REF_CLK), .drv({P3_OUT, P2_OUT, P1_OUT, P0_OUT}),
    .oe_n({P3_OE_N, P2_OE_N, P1_OE_N, P0_OE_N}), .pu({16'h0000, P1_PULLUP, P0_PULLUP}),
    .ext_en(ext_en), .ext_val(ext_val), .pin({P3_IN, P2_IN, P1_IN, P0_IN}));
  initial begin
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK) begin ADDR <= a; WDATA <= d; WR <= 1'b1; end
    @(posedge REF_CLK) WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge REF_CLK) begin ADDR <= a; RD <= 1'b1; end
    @(posedge REF_CLK) RD <= 1'b0;
    #1;
    `CHK("rdata", e, RDATA)
  endtask
  // Slot order: P0.4, P0.5, P3.4, P0.7
  task automatic pins(input logic [3:0] v);
    @(posedge REF_CLK) ext_val <= {ext_val[31:29], v[2], ext_val[27:8], v[3], ext_val[6], v[1:0], ext_val[3:0]};
    cyc(6);
  endtask
  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge REF_CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    $display("test reset done");
    wr(OFS_DIR1, 8'h00);
    wr(OFS_DATA1, 8'hA5);
    `CHK("p1 out", 8'hA5, P1_OUT)
    rd(OFS_DATA1, 8'hA5);
    wr(OFS_DIR0, 8'hFB);
    `CHK("p0 oe", 8'hF7, P0_OE_N)
    @(posedge REF_CLK) ext_val[7:0] <= 8'hFF;
    wr(OFS_DATA0, 8'hFF);
    `CHK("p0 out", 8'hF3, P0_OUT)
    rd(OFS_DATA0, 8'hF3);
    wr(OFS_DIR2, 8'h0F);
    wr(OFS_DATA2, 8'h3C);
    `CHK("p2 oe", 8'h0F, P2_OE_N)
    `CHK("p2 out", 8'h3C, P2_OUT)
    rd(OFS_DATA2, 8'h30);
    wr(OFS_DIR3, 8'hFE);
    wr(OFS_DATA3, 8'h01);
    `CHK("p3 oe", 8'hFE, P3_OE_N)
    `CHK("p3 out", 8'h01, P3_OUT)
    rd(OFS_DATA3, 8'h01);
    wr(OFS_PU1, 8'hFF);
    `CHK("p1 pu out", 8'h00, P1_PULLUP)
    wr(OFS_DIR1, 8'hFF);
    `CHK("p1 pu in", 8'hFF, P1_PULLUP)
    @(posedge REF_CLK) ext_en[15:8] <= 8'h00;
    rd(OFS_DATA1, 8'hFF);
    wr(OFS_PU0, 8'hFF);
    `CHK("p0 pu", 8'h80, P0_PULLUP)
    $display("test pins done");
    wr(OFS_WKEDGE, 8'h05);
    pins(4'hA);
    wr(OFS_WKEN, 8'h0F);
    pins(4'h5);
    rd(OFS_WKEN, 8'h0F);
    pins(4'hA);
    rd(OFS_WKEN, 8'hFF);
    wr(OFS_WKEN, 8'hDF);
    rd(OFS_WKEN, 8'hDF);
    wr(OFS_WKEN, 8'h0E);
    pins(4'hB);
    pins(4'hA);
    `CHK("wake awake", 1'b0, WAKE_RST)
    @(posedge REF_CLK) SLEEP <= 1'b1;
    pins(4'hB);
    `CHK("wake wrong edge", 1'b0, WAKE_RST)
    pins(4'hA);
    `CHK("wake sleep", 1'b1, WAKE_RST)
    $display("test wake done");
    @(posedge REF_CLK) RSTN <= 1'b0;
    @(posedge REF_CLK) SLEEP <= 1'b0;
    @(posedge REF_CLK) RSTN <= 1'b1;
    #1;
    `CHK("wake after reset", 1'b0, WAKE_RST)
    `CHK("p2 oe reset", 8'hFF, P2_OE_N)
    rd(OFS_WKEN, 8'h0F);
    $display("test rereset done");
    end_sim();
  end
endmodule
